//--- rtl/dpm_pkg.sv
// Constants and types for the dual-port memory port host controller
// Contract
// - Hosts bring both mailbox flags to a known state after power-up.
// - Held-off host keeps strobe low the write-hold time after indication rises.
// - Slave collision input must be present before the write strobe starts.
// - Avoid boundary scan while either port sleeps.
package dpm_pkg;

	localparam int          CLK_PERIOD_PS = 4000;
	localparam int          ADDR_W        = 18;
	localparam int          DATA_W        = 36;
	localparam int          LANES         = 4;

	localparam logic [17:0] MBX_TOP_FULL  = 18'h3ffff;
	localparam logic [17:0] MBX_LOW_FULL  = 18'h3fffe;
	localparam logic [17:0] MBX_TOP_HALF  = 18'h1ffff;
	localparam logic [17:0] MBX_LOW_HALF  = 18'h1fffe;

	// Collision indication settle time, a least wait
	localparam int          T_SETTLE_NS   = 15;
	// Write pulse width, own plain choice
	localparam int          T_PULSE_NS    = 12;
	// Write hold after collision indication rises
	localparam int          T_HOLD_NS     = 12;
	// Read access time, own plain choice
	localparam int          T_ACCESS_NS   = 15;

	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int          SETTLE_CYC    = ceil_cyc(T_SETTLE_NS);
	localparam int          PULSE_CYC     = ceil_cyc(T_PULSE_NS);
	localparam int          HOLD_CYC      = ceil_cyc(T_HOLD_NS);
	localparam int          ACCESS_CYC    = ceil_cyc(T_ACCESS_NS);

	typedef logic [3:0] dpm_cnt_t;

	localparam dpm_cnt_t    SETTLE_LOAD   = 4'(SETTLE_CYC - 1);
	localparam dpm_cnt_t    PULSE_LOAD    = 4'(PULSE_CYC - 1);
	localparam dpm_cnt_t    HOLD_LOAD     = 4'(HOLD_CYC - 1);
	localparam dpm_cnt_t    ACCESS_LOAD   = 4'(ACCESS_CYC - 1);

	typedef enum logic [2:0] {
		ST_INIT  = 3'b000,
		ST_IDLE  = 3'b001,
		ST_SETUP = 3'b010,
		ST_WRITE = 3'b011,
		ST_READ  = 3'b100,
		ST_REC   = 3'b101,
		ST_SLEEP = 3'b110
	} dpm_state_e;

	// Mailbox word for this port: own = the word it reads to clear its flag
	function automatic logic [17:0] mbx_addr(input logic is_left,
		input logic own, input logic half);
		logic top;
		top = is_left ^ own;
		if (half)
			return top ? MBX_TOP_HALF : MBX_LOW_HALF;
		else
			return top ? MBX_TOP_FULL : MBX_LOW_FULL;
	endfunction

endpackage

//--- rtl/dpm_tmr_if.sv
// Load and done handshake between the controller and its wait timer
interface dpm_tmr_if;
	import dpm_pkg::*;
	logic     load;
	dpm_cnt_t val;
	logic     done;
	modport ctl (output load, output val, input done);
	modport tmr (input load, input val, output done);
endinterface

//--- rtl/dpm_wait.sv
// Down-counting wait timer for pin timing
module dpm_wait
	import dpm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	dpm_tmr_if.tmr    tb
);
	typedef struct packed {
		dpm_cnt_t cnt;
	} dpm_wait_s;

	dpm_wait_s s_reg;
	dpm_wait_s s_next;

	always_comb begin
		s_next = s_reg;
		if (tb.load)
			s_next.cnt = tb.val;
		else if (s_reg.cnt != 4'h0)
			s_next.cnt = s_reg.cnt - 4'h1;
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign tb.done = (s_reg.cnt == 4'h0);
endmodule

//--- rtl/dpm_host.sv
// Host controller driving one port of the dual-port memory
module dpm_host
	import dpm_pkg::*;
#(
	parameter bit IS_LEFT    = 1'b1,
	parameter bit HALF_DEPTH = 1'b0
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_write,
	input  wire logic              req_mbx,
	input  wire logic [17:0]       req_addr,
	input  wire logic [35:0]       req_wdata,
	input  wire logic [3:0]        req_be,
	output logic                   rsp_valid,
	output logic [35:0]            rsp_rdata,
	output logic                   rsp_collided,
	input  wire logic              sleep_req,
	output logic                   mailbox_pending,
	output logic [17:0]            address,
	output logic [35:0]            data_out,
	output logic                   data_oe_n,
	input  wire logic [35:0]       data_in,
	output logic                   port_enable_active_low_n,
	output logic                   port_enable_active_high,
	output logic [3:0]             byte_lane_enable_n,
	output logic                   write_strobe_n,
	output logic                   output_enable_n,
	output logic                   flag_space_select_n,
	output logic                   port_sleep_input,
	input  wire logic              collision_indication_n,
	input  wire logic              mailbox_flag_n
);
	typedef struct packed {
		dpm_state_e  st;
		logic [17:0] addr;
		logic [35:0] wdata;
		logic [3:0]  be_n;
		logic [35:0] rdata;
		logic        quiet;
		logic        rsp;
		logic        collided;
	} dpm_host_s;

	dpm_host_s s_reg;
	dpm_host_s s_next;
	logic      tmr_load;
	dpm_cnt_t  tmr_val;

	dpm_tmr_if tif ();

	dpm_wait u_wait (
		.clk_sys (clk_sys),
		.rst     (rst),
		.tb      (tif.tmr)
	);

	assign tif.load = tmr_load;
	assign tif.val  = tmr_val;

	always_comb begin
		s_next     = s_reg;
		s_next.rsp = 1'b0;
		tmr_load   = 1'b0;
		tmr_val    = 4'h0;
		case (s_reg.st)
		ST_INIT: begin
			// Own flag has no known value until its mailbox is read
			s_next.addr     = mbx_addr(IS_LEFT, 1'b1, HALF_DEPTH);
			s_next.be_n     = 4'h0;
			s_next.quiet    = 1'b1;
			s_next.collided = 1'b0;
			tmr_load        = 1'b1;
			tmr_val         = ACCESS_LOAD;
			s_next.st       = ST_READ;
		end
		ST_IDLE: begin
			if (sleep_req) begin
				s_next.st = ST_SLEEP;
			end else if (req_valid) begin
				// Write goes to partner box, read to own box
				s_next.addr     = req_mbx ?
					mbx_addr(IS_LEFT, !req_write, HALF_DEPTH) : req_addr;
				s_next.wdata    = req_wdata;
				s_next.be_n     = req_write ? ~req_be : 4'h0;
				s_next.quiet    = 1'b0;
				s_next.collided = 1'b0;
				tmr_load        = 1'b1;
				if (req_write) begin
					tmr_val   = SETTLE_LOAD;
					s_next.st = ST_SETUP;
				end else begin
					tmr_val   = ACCESS_LOAD;
					s_next.st = ST_READ;
				end
			end
		end
		ST_SETUP: begin
			// Indication settles before the write strobe, as a slave needs
			if (tif.done) begin
				tmr_load  = 1'b1;
				tmr_val   = PULSE_LOAD;
				s_next.st = ST_WRITE;
			end
		end
		ST_WRITE: begin
			// Strobe stretched while blocked, then held the hold time
			if (!collision_indication_n) begin
				tmr_load        = 1'b1;
				tmr_val         = HOLD_LOAD;
				s_next.collided = 1'b1;
			end else if (tif.done) begin
				s_next.rsp = 1'b1;
				s_next.st  = ST_REC;
			end
		end
		ST_READ: begin
			// Read restarts while flagged, so the clear lands unblocked
			if (!collision_indication_n) begin
				tmr_load        = 1'b1;
				tmr_val         = ACCESS_LOAD;
				s_next.collided = 1'b1;
			end else if (tif.done) begin
				s_next.rdata = data_in;
				s_next.rsp   = !s_reg.quiet;
				s_next.st    = ST_REC;
			end
		end
		ST_REC: begin
			// One idle cycle so enables release before the next access
			s_next.st = ST_IDLE;
		end
		ST_SLEEP: begin
			if (!sleep_req)
				s_next.st = ST_IDLE;
		end
		default: begin
			s_next.st = ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg    <= '0;
			s_reg.st <= ST_INIT;
		end else begin
			s_reg <= s_next;
		end
	end

	logic ce_on;
	assign ce_on = (s_reg.st == ST_SETUP) || (s_reg.st == ST_WRITE) ||
		(s_reg.st == ST_READ);

	assign req_ready                = (s_reg.st == ST_IDLE) && !sleep_req;
	assign rsp_valid                = s_reg.rsp;
	assign rsp_rdata                = s_reg.rdata;
	assign rsp_collided             = s_reg.collided;
	// Flag pin still works in sleep
	assign mailbox_pending          = !mailbox_flag_n;
	assign address                  = s_reg.addr;
	assign data_out                 = s_reg.wdata;
	assign data_oe_n                = !((s_reg.st == ST_SETUP) ||
		(s_reg.st == ST_WRITE));
	// Both enables move together so the composite enable is clean
	assign port_enable_active_low_n = !ce_on;
	assign port_enable_active_high  = ce_on;
	assign byte_lane_enable_n       = ce_on ? s_reg.be_n : 4'hf;
	assign write_strobe_n           = !(s_reg.st == ST_WRITE);
	assign output_enable_n          = !(s_reg.st == ST_READ);
	assign flag_space_select_n      = 1'b1;
	// Sleep only entered from idle, so no access is cut short
	// No scan logic here, so no scan runs while asleep
	assign port_sleep_input         = (s_reg.st == ST_SLEEP);

	init_read_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		$fell(rst) |-> ##[0:2] (!output_enable_n &&
		address == mbx_addr(IS_LEFT, 1'b1, HALF_DEPTH)))
		else $error("own mailbox not read after reset");

	hold_after_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		(!write_strobe_n && !collision_indication_n) ##1
		collision_indication_n |-> !write_strobe_n [*3])
		else $error("write strobe released too early after collision");

	strobe_setup_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		$fell(write_strobe_n) |-> !$past(port_enable_active_low_n, 4) &&
		$stable(address))
		else $error("write strobe started before settle time");

	sleep_quiet_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		port_sleep_input |-> port_enable_active_low_n && write_strobe_n &&
		output_enable_n)
		else $error("access driven during sleep");

	blocked_write_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		(!write_strobe_n && !collision_indication_n) |=> !write_strobe_n)
		else $error("blocked write abandoned");

	stall_c: cover property (@(posedge clk_sys) disable iff (rst)
		!write_strobe_n && !collision_indication_n);

	send_c: cover property (@(posedge clk_sys) disable iff (rst)
		req_valid && req_ready && req_write && req_mbx);

	mbx_read_c: cover property (@(posedge clk_sys) disable iff (rst)
		rsp_valid && !mailbox_pending &&
		address == mbx_addr(IS_LEFT, 1'b1, HALF_DEPTH));
endmodule

//--- verification/dpm_dev_model.sv
// Behavioural memory device seen at one host port
module dpm_dev_model
	import dpm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic [17:0] addr,
	input  wire logic [35:0] dout,
	input  wire logic        ce_n,
	input  wire logic        ce_h,
	input  wire logic [3:0]  be_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        sleep,
	input  wire logic        peer_hold,
	input  wire logic        peer_set,
	input  wire logic        peer_clr,
	output logic [35:0]      din,
	output logic             busy_n,
	output logic             own_flag_n,
	output logic             peer_flag_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [35:0] mem [logic [17:0]];
	logic [35:0] last = 36'h0;
	logic [35:0] w;
	logic        sel;
	// Flags power up set, so the host must clear its own
	initial own_flag_n = 1'b0;
	initial peer_flag_n = 1'b0;
	assign sel = !ce_n && ce_h && !sleep;
	// Peer settled first; any selected address is held off, no address compare
	// Only this port is flagged, setup window moot
	assign busy_n = !(peer_hold && sel);
	// Undriven bus shows the inverse of its last value
	always @* begin
		din = (sel && !oe_n && mem.exists(addr)) ? mem[addr] : ~last;
	end
	always @(posedge clk_sys) begin
		if (sel && !we_n && busy_n) begin
			w = mem.exists(addr) ? mem[addr] : ~last;
			for (int i = 0; i < 4; i++)
				if (!be_n[i]) w[i*9+:9] = dout[i*9+:9];
			mem[addr] = w;
			if (addr == MBX_TOP_FULL) peer_flag_n <= 1'b0;
		end
		if (sel && !oe_n && busy_n && addr == MBX_LOW_FULL)
			own_flag_n <= 1'b1;
		if (peer_set) own_flag_n <= 1'b0;
		if (peer_clr) peer_flag_n <= 1'b1;
		last <= din;
	end
endmodule

//--- verification/dpm_host_tb.sv
// Self-checking bench for the left-port host controller
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module dpm_host_tb;
	import dpm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rst = 1, req_valid = 0, req_write = 0, req_mbx = 0;
	logic sleep_req = 0, peer_hold = 0, peer_set = 0, peer_clr = 0;
	logic req_ready, rsp_valid, rsp_collided, mailbox_pending, data_oe_n;
	logic port_enable_active_low_n, port_enable_active_high, write_strobe_n;
	logic output_enable_n, flag_space_select_n, port_sleep_input;
	logic collision_indication_n, mailbox_flag_n, peer_flag_n;
	logic [17:0] req_addr = 0, address;
	logic        r_valid = 0, r_oe_n, r_we_n;
	logic [17:0] r_addr;
	logic [35:0] req_wdata = 0, rsp_rdata, data_out, data_in;
	logic [3:0]  req_be = 0, byte_lane_enable_n;
	logic [35:0] mirror [logic [17:0]];
	int n_fail = 0, n_compared = 0;
	always #2 clk_sys = ~clk_sys;
	dpm_host dut_u (.clk_sys, .rst, .req_valid, .req_ready, .req_write,
		.req_mbx, .req_addr, .req_wdata, .req_be, .rsp_valid, .rsp_rdata,
		.rsp_collided, .sleep_req, .mailbox_pending, .address, .data_out,
		.data_oe_n, .data_in, .port_enable_active_low_n,
		.port_enable_active_high, .byte_lane_enable_n, .write_strobe_n,
		.output_enable_n, .flag_space_select_n, .port_sleep_input,
		.collision_indication_n, .mailbox_flag_n);
	dpm_dev_model dev_u (.clk_sys, .addr(address), .dout(data_out),
		.ce_n(port_enable_active_low_n), .ce_h(port_enable_active_high),
		.be_n(byte_lane_enable_n), .we_n(write_strobe_n),
		.oe_n(output_enable_n), .sleep(port_sleep_input), .peer_hold,
		.peer_set, .peer_clr, .din(data_in), .busy_n(collision_indication_n),
		.own_flag_n(mailbox_flag_n), .peer_flag_n);
	// Right role at half depth, only its mailbox addressing is checked
	dpm_host #(.IS_LEFT(1'b0), .HALF_DEPTH(1'b1)) dut_r_u (.clk_sys, .rst,
		.req_valid(r_valid), .req_ready(), .req_write, .req_mbx,
		.req_addr, .req_wdata, .req_be, .rsp_valid(), .rsp_rdata(),
		.rsp_collided(), .sleep_req(1'b0), .mailbox_pending(),
		.address(r_addr), .data_out(), .data_oe_n(), .data_in(36'h0),
		.port_enable_active_low_n(), .port_enable_active_high(),
		.byte_lane_enable_n(), .write_strobe_n(r_we_n),
		.output_enable_n(r_oe_n), .flag_space_select_n(),
		.port_sleep_input(), .collision_indication_n(1'b1),
		.mailbox_flag_n(1'b1));
	function automatic logic [35:0] merge(input logic [35:0] o, n,
		input logic [3:0] be);
		merge = o;
		for (int i = 0; i < 4; i++)
			if (be[i]) merge[i*9+:9] = n[i*9+:9];
	endfunction
	task automatic close_out();
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic pulse(input bit s);
		peer_set = s;
		peer_clr = !s;
		@(posedge clk_sys);
		#1 peer_set = 0;
		peer_clr = 0;
		@(posedge clk_sys);
		#1;
	endtask
	// Collision starts at the take edge and lasts hold cycles
	task automatic do_req(input logic wr, mbx, input logic [17:0] a,
		input logic [35:0] d, input logic [3:0] be, input int hold);
		int n;
		int c;
		int lat;
		logic [17:0] ra;
		{req_write, req_mbx, req_addr, req_wdata, req_be} = {wr, mbx, a, d, be};
		req_valid = 1;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			#1 n++;
		end
		`CHK("ready", 1'b1, req_ready)
		@(posedge clk_sys);
		#1 req_valid = 0;
		peer_hold = (hold > 0);
		c = 0;
		while (rsp_valid !== 1'b1 && c < 80) begin
			`CHK("enable", 1'b1, port_enable_active_high)
			@(posedge clk_sys);
			#1 c++;
			if (c == hold) begin
				if (mbx && !wr) `CHK("held flag", 1'b1, mailbox_pending)
				peer_hold = 0;
			end
		end
		`CHK("response", 1'b1, rsp_valid)
		lat = wr ? SETTLE_CYC + PULSE_CYC : ACCESS_CYC;
		if (hold == 0) `CHK("latency", lat, c)
		`CHK("collided", hold > 0, rsp_collided)
		ra = mbx ? (wr ? MBX_TOP_FULL : MBX_LOW_FULL) : a;
		if (wr)
			mirror[ra] = merge(mirror.exists(ra) ? mirror[ra] : 36'h0, d, be);
		else if (mirror.exists(ra))
			`CHK("rdata", mirror[ra], rsp_rdata)
		@(posedge clk_sys);
		#1 `CHK("idle enable", 1'b1, port_enable_active_low_n)
	endtask
	initial begin
		#40000 n_fail++;
		close_out();
	end
	initial begin
		int n;
		void'($urandom(32'h33e5));
		repeat (4) @(posedge clk_sys);
		#1 rst = 0;
		@(posedge clk_sys);
		#1 `CHK("right init", {1'b0, MBX_TOP_HALF}, {r_oe_n, r_addr})
		`CHK("left init", {1'b0, MBX_LOW_FULL}, {output_enable_n, address})
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			#1 n++;
		end
		`CHK("init ready", 1'b1, req_ready)
		`CHK("init flag", 1'b0, mailbox_pending)
		pulse(0);
		for (int i = 0; i < 8; i++)
			do_req(1, 0, 18'(i), 36'({$urandom, $urandom}), 4'hf, 0);
		for (int k = 0; k < 30; k++)
			do_req(1'($urandom % 2), 0, 18'($urandom_range(7)),
				36'({$urandom, $urandom}), 4'($urandom), 0);
		do_req(1, 0, 18'h3, 36'h9_a5a5_5a5a, 4'h5, 6);
		do_req(0, 0, 18'h3, 36'h0, 4'h0, 3);
		do_req(1, 1, 18'h0, 36'h1_2345_6789, 4'hf, 0);
		`CHK("peer flag set", 1'b0, peer_flag_n)
		pulse(0);
		`CHK("peer flag clear", 1'b1, peer_flag_n)
		pulse(1);
		`CHK("own flag set", 1'b1, mailbox_pending)
		do_req(0, 1, 18'h0, 36'h0, 4'h0, 4);
		`CHK("own flag clear", 1'b0, mailbox_pending)
		sleep_req = 1;
		repeat (2) @(posedge clk_sys);
		#1 `CHK("sleep pin", 1'b1, port_sleep_input)
		`CHK("sleep ready", 1'b0, req_ready)
		pulse(1);
		`CHK("sleep flag", 1'b1, mailbox_pending)
		sleep_req = 0;
		do_req(0, 1, 18'h0, 36'h0, 4'h0, 0);
		`CHK("wake clear", 1'b0, mailbox_pending)
		{req_write, req_mbx} = 2'b11;
		r_valid = 1;
		@(posedge clk_sys);
		#1 r_valid = 0;
		repeat (SETTLE_CYC) @(posedge clk_sys);
		#1 `CHK("right box", {1'b0, MBX_LOW_HALF}, {r_we_n, r_addr})
		close_out();
	end
endmodule
